/* File: shared/page_addr_pkg.sv */
// Purpose: constants and carriers for the paged data-space address unit
// Assumes: 16-bit data addresses, 10-bit page registers
// Notes: page codes follow the paged window layout
package page_addr_pkg;
  // ==========================================================
  // Widths and page codes
  localparam int EA_W = 16;
  localparam int PAG_W = 10;
  localparam int EA_WIN_BIT = 15;
  localparam logic [PAG_W-1:0] PAG_ZERO = 10'h000;
  localparam logic [PAG_W-1:0] PAG_ONE = 10'h001;
  localparam logic [PAG_W-1:0] PAG_EDS_LAST = 10'h1FF;
  localparam logic [PAG_W-1:0] PAG_PSV_LSW_FIRST = 10'h200;
  localparam logic [PAG_W-1:0] PAG_PSV_LSW_LAST = 10'h2FF;
  localparam logic [PAG_W-1:0] PAG_PSV_MSW_FIRST = 10'h300;
  localparam logic [PAG_W-1:0] PAG_PSV_MSW_LAST = 10'h3FF;
  localparam logic [PAG_W-1:0] PAG_RESET = 10'h001;
  localparam int PSV_BIT = 9;

  // ==========================================================
  // Addressing modes
  typedef enum logic [2:0] {
    MODE_DIRECT = 3'h0,
    MODE_IND_PRE = 3'h1,
    MODE_IND_POST = 3'h2,
    MODE_IND_OFFSET = 3'h3,
    MODE_MODULO = 3'h4,
    MODE_BITREV = 3'h5
  } addr_mode_t;

  // Request from the execution unit
  typedef struct packed {
    logic valid;
    logic write;
    addr_mode_t mode;
    logic [EA_W-1:0] base;
    logic [EA_W:0] raw_ea;
  } ea_req_t;

  // Result towards the data bus
  typedef struct packed {
    logic valid;
    logic write;
    logic [EA_W-1:0] ea;
    logic [PAG_W-1:0] page;
    logic paged;
    logic addr_err;
  } ea_rsp_t;

  // Unit result and trap state machine
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RESULT = 3'b010,
    ST_TRAP = 3'b100
  } unit_state_t;
endpackage

/* File: src/page_step.sv */
// Purpose: combinational page correction for one crossing
// Assumes: inputs stable in the cycle of use
// Notes: boundary cases of the paged spaces handled here
module page_step
  import page_addr_pkg::*;
(
  // Crossing
  input wire logic [PAG_W-1:0] page,
  input wire logic is_read,
  input wire logic ovf,
  input wire logic unf,
  // Result
  output logic [PAG_W-1:0] page_out,
  output logic win_bit
);
  // ==========================================================
  // Boundary table
  always_comb begin
    page_out = page;
    win_bit = 1'b1;
    if (ovf) begin
      if (page == PAG_EDS_LAST || page == PAG_PSV_MSW_LAST) begin
        win_bit = 1'b0;
      end else if (is_read && page == PAG_PSV_LSW_LAST) begin
        page_out = PAG_PSV_MSW_FIRST;
      end else begin
        page_out = page + PAG_ONE;
      end
    end else if (unf) begin
      if (page == PAG_ONE || page == PAG_PSV_LSW_FIRST) begin
        win_bit = 1'b0;
      end else if (is_read && page == PAG_PSV_MSW_FIRST) begin
        page_out = PAG_PSV_LSW_LAST;
      end else begin
        page_out = page - PAG_ONE;
      end
    end
  end
endmodule

/* File: src/paged_data_space_address_unit.sv */
// Purpose: effective address and page handling for paged data access
// Assumes: one request per cycle, result one cycle later
// Notes: page registers loaded from the core by load strobes
// Operation
// - Separate read and write page registers; direction selects which one is used.
// - Read from program visible page and write extended page in one instruction.
// - Crossing clears effective address bit 15 before correction.
// - Crossing counts only from paged window, in every addressing mode.
// - Overflow increments active page and sets bit 15.
// - Underflow decrements active page and sets bit 15.
// - Page stepping only in pre/post modified indirect modes.
// - Page zero, extended and program-visible boundaries get special handling.
// - Offset, modulo, bit-reversed crossings set bit 15, page unchanged.
// - Overflow from last extended or last upper page clears bit 15.
// - Read page steps between last lower and first upper page.
// - Extended access with page zero raises address error.
// - Writes into program space raise address error.
module paged_data_space_address_unit
  import page_addr_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Page register loads
  input wire logic rd_page_load,
  input wire logic wr_page_load,
  input wire logic [PAG_W-1:0] page_wdata,
  // Request
  input wire ea_req_t req,
  // Result
  output ea_rsp_t rsp,
  output logic [PAG_W-1:0] read_page_select,
  output logic [PAG_W-1:0] write_page_select,
  output logic addr_err_trap
);
  // ==========================================================
  // State
  logic [PAG_W-1:0] rd_pag_r, rd_pag_nxt, wr_pag_r, wr_pag_nxt;
  ea_rsp_t rsp_r, rsp_nxt;
  unit_state_t state_r, state_nxt;
  logic [PAG_W-1:0] active_page_select, stepped_page;
  logic in_window, indirect_mod, wrap_mode, ovf, unf, stepped_win;
  logic [EA_W-1:0] effective_address;

  function automatic logic is_indirect(input addr_mode_t m);
    return (m == MODE_IND_PRE) || (m == MODE_IND_POST);
  endfunction

  // ==========================================================
  // Crossing detection
  always_comb begin
    active_page_select = req.write ? wr_pag_r : rd_pag_r;
    in_window = req.base[EA_WIN_BIT];
    indirect_mod = is_indirect(req.mode);
    wrap_mode = (req.mode == MODE_IND_OFFSET) || (req.mode == MODE_MODULO) ||
                (req.mode == MODE_BITREV);
    // Carry beyond 16 bits or bit 15 dropping out marks a crossing
    ovf = in_window && req.raw_ea[EA_W];
    unf = in_window && !req.raw_ea[EA_W] && !req.raw_ea[EA_WIN_BIT];
    effective_address = req.raw_ea[EA_W-1:0];
    if (ovf || unf) begin
      effective_address[EA_WIN_BIT] = 1'b0;
    end
  end

  page_step u_step (
    .page(active_page_select),
    .is_read(!req.write),
    .ovf(ovf && indirect_mod),
    .unf(unf && indirect_mod),
    .page_out(stepped_page),
    .win_bit(stepped_win)
  );

  // ==========================================================
  // Next values
  always_comb begin
    rd_pag_nxt = rd_pag_r;
    wr_pag_nxt = wr_pag_r;
    rsp_nxt = '0;
    state_nxt = ST_IDLE;
    if (rd_page_load) begin
      rd_pag_nxt = page_wdata;
    end
    if (wr_page_load) begin
      wr_pag_nxt = page_wdata;
    end
    if (req.valid) begin
      rsp_nxt.valid = 1'b1;
      rsp_nxt.write = req.write;
      rsp_nxt.page = active_page_select;
      rsp_nxt.ea = effective_address;
      if ((ovf || unf) && indirect_mod) begin
        rsp_nxt.ea[EA_WIN_BIT] = stepped_win;
        rsp_nxt.page = stepped_page;
        if (req.write) begin
          wr_pag_nxt = stepped_page;
        end else begin
          rd_pag_nxt = stepped_page;
        end
      end else if ((ovf || unf) && wrap_mode) begin
        rsp_nxt.ea[EA_WIN_BIT] = 1'b1;
      end
      rsp_nxt.paged = rsp_nxt.ea[EA_WIN_BIT];
      if (rsp_nxt.paged && rsp_nxt.page == PAG_ZERO) begin
        rsp_nxt.addr_err = 1'b1;
      end
      if (rsp_nxt.paged && req.write && rsp_nxt.page[PSV_BIT]) begin
        rsp_nxt.addr_err = 1'b1;
      end
      state_nxt = rsp_nxt.addr_err ? ST_TRAP : ST_RESULT;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rd_pag_r <= PAG_RESET;
      wr_pag_r <= PAG_RESET;
      rsp_r <= '0;
      state_r <= ST_IDLE;
    end else begin
      rd_pag_r <= rd_pag_nxt;
      wr_pag_r <= wr_pag_nxt;
      rsp_r <= rsp_nxt;
      state_r <= state_nxt;
    end
  end

  assign rsp = rsp_r;
  assign read_page_select = rd_pag_r;
  assign write_page_select = wr_pag_r;
  assign addr_err_trap = (state_r == ST_TRAP);

  // ==========================================================
  // Checks
  property p_wr_psv_trap;
    @(posedge clk) disable iff (!reset_n)
    rsp.valid && rsp.write && rsp.paged && rsp.page[PSV_BIT] |-> addr_err_trap;
  endproperty
  a_wr_psv_trap: assert property (p_wr_psv_trap) else $error("program space write not trapped");

  property p_zero_trap;
    @(posedge clk) disable iff (!reset_n)
    rsp.valid && rsp.paged && rsp.page == PAG_ZERO |-> rsp.addr_err;
  endproperty
  a_zero_trap: assert property (p_zero_trap) else $error("page zero access not trapped");

  property p_wrap_keeps_page;
    @(posedge clk) disable iff (!reset_n)
    req.valid && (ovf || unf) && wrap_mode && !rd_page_load && !wr_page_load
      |=> rsp.ea[EA_WIN_BIT] && $stable(read_page_select) && $stable(write_page_select);
  endproperty
  a_wrap_keeps_page: assert property (p_wrap_keeps_page) else $error("wrap mode changed page");

  property p_direct_no_step;
    @(posedge clk) disable iff (!reset_n)
    req.valid && !indirect_mod && !rd_page_load && !wr_page_load |=> $stable(read_page_select) &&
      $stable(write_page_select);
  endproperty
  a_direct_no_step: assert property (p_direct_no_step) else $error("page stepped outside indirect");

  property p_ovf_inc;
    @(posedge clk) disable iff (!reset_n)
    req.valid && !req.write && ovf && indirect_mod && !rd_page_load && rd_pag_r == PAG_ONE
      |=> read_page_select == PAG_ONE + PAG_ONE && rsp.ea[EA_WIN_BIT];
  endproperty
  a_ovf_inc: assert property (p_ovf_inc) else $error("overflow did not increment");

  // Boundary pages excluded: they keep their page on underflow
  property p_unf_dec;
    @(posedge clk) disable iff (!reset_n)
    req.valid && req.write && unf && indirect_mod && !wr_page_load && wr_pag_r != PAG_ONE &&
      wr_pag_r != PAG_PSV_LSW_FIRST
      |=> write_page_select == $past(wr_pag_r) - PAG_ONE && rsp.ea[EA_WIN_BIT];
  endproperty
  a_unf_dec: assert property (p_unf_dec) else $error("underflow did not decrement");

  property p_rd_page_used;
    @(posedge clk) disable iff (!reset_n)
    req.valid && !req.write && !((ovf || unf) && indirect_mod) |=> rsp.page == $past(rd_pag_r);
  endproperty
  a_rd_page_used: assert property (p_rd_page_used) else $error("read did not use read page");

  property p_wr_page_used;
    @(posedge clk) disable iff (!reset_n)
    req.valid && req.write && !((ovf || unf) && indirect_mod) |=> rsp.page == $past(wr_pag_r);
  endproperty
  a_wr_page_used: assert property (p_wr_page_used) else $error("write did not use write page");

  property p_outside_no_step;
    @(posedge clk) disable iff (!reset_n)
    req.valid && !in_window && !rd_page_load && !wr_page_load
      |=> $stable(read_page_select) && $stable(write_page_select);
  endproperty
  a_outside_no_step: assert property (p_outside_no_step) else $error("page stepped outside window");

  property p_msw_lsw;
    @(posedge clk) disable iff (!reset_n)
    req.valid && !req.write && unf && indirect_mod && rd_pag_r == PAG_PSV_MSW_FIRST && !rd_page_load
      |=> read_page_select == PAG_PSV_LSW_LAST && rsp.ea[EA_WIN_BIT];
  endproperty
  a_msw_lsw: assert property (p_msw_lsw) else $error("upper to lower page step wrong");

  property p_first_page_unf;
    @(posedge clk) disable iff (!reset_n)
    req.valid && unf && indirect_mod &&
      (active_page_select == PAG_ONE || active_page_select == PAG_PSV_LSW_FIRST)
      |=> !rsp.ea[EA_WIN_BIT] && rsp.page == $past(active_page_select);
  endproperty
  a_first_page_unf: assert property (p_first_page_unf) else $error("first page underflow wrong");

  property p_last_msw;
    @(posedge clk) disable iff (!reset_n)
    req.valid && !req.write && ovf && indirect_mod && rd_pag_r == PAG_PSV_MSW_LAST
      |=> !rsp.ea[EA_WIN_BIT] && rsp.page == PAG_PSV_MSW_LAST;
  endproperty
  a_last_msw: assert property (p_last_msw) else $error("last upper page overflow wrong");

  property p_trap_follows;
    @(posedge clk) disable iff (!reset_n)
    rsp.valid && rsp.addr_err |-> addr_err_trap;
  endproperty
  a_trap_follows: assert property (p_trap_follows) else $error("address error without trap");

  property p_last_eds;
    @(posedge clk) disable iff (!reset_n)
    req.valid && ovf && indirect_mod && active_page_select == PAG_EDS_LAST
      |=> !rsp.ea[EA_WIN_BIT] && rsp.page == PAG_EDS_LAST;
  endproperty
  a_last_eds: assert property (p_last_eds) else $error("last extended page overflow wrong");

  property p_lsw_msw;
    @(posedge clk) disable iff (!reset_n)
    req.valid && !req.write && ovf && indirect_mod && rd_pag_r == PAG_PSV_LSW_LAST && !rd_page_load
      |=> read_page_select == PAG_PSV_MSW_FIRST && rsp.ea[EA_WIN_BIT];
  endproperty
  a_lsw_msw: assert property (p_lsw_msw) else $error("lower to upper page step wrong");
endmodule

/* File: test/exec_unit_model.sv */
// Purpose: execution-unit side model driving page loads and address requests
// Assumes: everything is driven on the falling clock edge
// Notes: no memory data is modelled, only the address request side
module exec_unit_model
  import page_addr_pkg::*;
(
  // Clock
  input wire logic clk,
  // Towards the unit
  output ea_req_t req,
  output logic rd_page_load,
  output logic wr_page_load,
  output logic [PAG_W-1:0] page_wdata
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    req = '0;
    rd_page_load = 1'b0;
    wr_page_load = 1'b0;
    page_wdata = '0;
  end

  // ==========================================================
  // Page load, one cycle strobe
  task automatic load_page(input logic w, input logic [PAG_W-1:0] pg);
    @(negedge clk);
    rd_page_load = !w;
    wr_page_load = w;
    page_wdata = pg;
    @(negedge clk);
    rd_page_load = 1'b0;
    wr_page_load = 1'b0;
    // Stale data not left on the load bus
    page_wdata = ~pg;
  endtask

  // ==========================================================
  // Request, held until the next issue or idle call; a second call gives back to back
  task automatic issue(input logic w, input addr_mode_t md, input logic [EA_W-1:0] b, input logic [EA_W:0] r);
    @(negedge clk);
    req = '{valid: 1'b1, write: w, mode: md, base: b, raw_ea: r};
  endtask

  task automatic idle();
    @(negedge clk);
    req.valid = 1'b0;
    req.base = ~req.base;
  endtask
endmodule

/* File: test/paged_data_space_address_unit_tb_top.sv */
// Purpose: self-checking bench for the paged address unit
// Assumes: result one cycle after the request
// Notes: table rows for crossings and address errors, hand tests for reset and moves
module paged_data_space_address_unit_tb_top;
  import page_addr_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct packed {
    logic w;
    addr_mode_t md;
    logic [15:0] b;
    logic [16:0] r;
    logic [9:0] pg;
    logic [15:0] ea;
    logic [9:0] np;
    logic err;
  } row_t;

  logic clk = 1'b0;
  logic reset_n = 1'b0;
  ea_req_t req;
  ea_rsp_t rsp;
  logic rd_page_load, wr_page_load, addr_err_trap;
  logic [9:0] page_wdata, read_page_select, write_page_select;
  int failures = 0;
  int n_compared = 0;

  // ==========================================================
  // Rows: dir, mode, base, modified, page, address, new page, error
  row_t rows [16] = '{
    '{1'b0, MODE_IND_PRE, 16'hFFFE, 17'h10000, 10'h001, 16'h8000, 10'h002, 1'b0},
    '{1'b1, MODE_IND_POST, 16'h8000, 17'h07FFE, 10'h005, 16'hFFFE, 10'h004, 1'b0},
    '{1'b0, MODE_IND_OFFSET, 16'hFFFE, 17'h10000, 10'h005, 16'h8000, 10'h005, 1'b0},
    '{1'b1, MODE_MODULO, 16'hFFFE, 17'h10000, 10'h005, 16'h8000, 10'h005, 1'b0},
    '{1'b1, MODE_BITREV, 16'h8000, 17'h07FFE, 10'h005, 16'hFFFE, 10'h005, 1'b0},
    '{1'b0, MODE_DIRECT, 16'hFFFE, 17'h10000, 10'h005, 16'h0000, 10'h005, 1'b0},
    '{1'b0, MODE_IND_PRE, 16'h7FFE, 17'h08000, 10'h005, 16'h8000, 10'h005, 1'b0},
    '{1'b0, MODE_IND_POST, 16'hFFFE, 17'h10000, 10'h1FF, 16'h0000, 10'h1FF, 1'b0},
    '{1'b0, MODE_IND_PRE, 16'hFFFE, 17'h10000, 10'h2FF, 16'h8000, 10'h300, 1'b0},
    '{1'b0, MODE_IND_POST, 16'hFFFE, 17'h10000, 10'h3FF, 16'h0000, 10'h3FF, 1'b0},
    '{1'b0, MODE_IND_PRE, 16'h8000, 17'h07FFE, 10'h300, 16'hFFFE, 10'h2FF, 1'b0},
    '{1'b0, MODE_IND_POST, 16'h8000, 17'h07FFE, 10'h001, 16'h7FFE, 10'h001, 1'b0},
    '{1'b0, MODE_IND_PRE, 16'h8000, 17'h07FFE, 10'h200, 16'h7FFE, 10'h200, 1'b0},
    '{1'b1, MODE_IND_POST, 16'hFFFE, 17'h10000, 10'h1FF, 16'h0000, 10'h1FF, 1'b0},
    '{1'b1, MODE_IND_POST, 16'h8000, 17'h08002, 10'h000, 16'h8002, 10'h000, 1'b1},
    '{1'b1, MODE_IND_POST, 16'h8000, 17'h08002, 10'h200, 16'h8002, 10'h200, 1'b1}
  };

  initial begin
    forever #2 clk = ~clk;
  end

  exec_unit_model m (.clk(clk), .req(req), .rd_page_load(rd_page_load), .wr_page_load(wr_page_load),
    .page_wdata(page_wdata));

  paged_data_space_address_unit dut (.clk(clk), .reset_n(reset_n), .rd_page_load(rd_page_load),
    .wr_page_load(wr_page_load), .page_wdata(page_wdata), .req(req), .rsp(rsp),
    .read_page_select(read_page_select), .write_page_select(write_page_select),
    .addr_err_trap(addr_err_trap));

  // ==========================================================
  // Compare and report
  task automatic chk_vec(input string n, input logic [16:0] e, input logic [16:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_bit(input string n, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %b seen %b", n, e, g);
    end
  endtask

  task automatic chk_rsp(input logic w, input logic [15:0] ea, input logic [9:0] pg, input logic err);
    chk_bit("valid", 1'b1, rsp.valid);
    chk_bit("write", w, rsp.write);
    chk_vec("ea", 17'(ea), 17'(rsp.ea));
    chk_vec("page", 17'(pg), 17'(rsp.page));
    chk_bit("paged", ea[15], rsp.paged);
    chk_bit("addr_err", err, rsp.addr_err);
    chk_bit("trap", err, addr_err_trap);
  endtask

  task automatic final_report();
    if (failures == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    #100000;
    failures++;
    final_report();
  end

  initial begin
    repeat (5) @(negedge clk);
    reset_n = 1'b1;
    chk_vec("rd page reset", 17'h001, 17'(read_page_select));
    chk_vec("wr page reset", 17'h001, 17'(write_page_select));
    chk_bit("valid reset", 1'b0, rsp.valid);
    foreach (rows[i]) begin
      m.load_page(rows[i].w, rows[i].pg);
      m.issue(rows[i].w, rows[i].md, rows[i].b, rows[i].r);
      m.idle();
      chk_rsp(rows[i].w, rows[i].ea, rows[i].np, rows[i].err);
      chk_vec("active page", 17'(rows[i].np),
        17'(rows[i].w ? write_page_select : read_page_select));
    end
    // Program-visible read then extended write, back to back
    m.load_page(1'b0, 10'h200);
    m.load_page(1'b1, 10'h005);
    chk_vec("rd page", 17'h200, 17'(read_page_select));
    chk_vec("wr page", 17'h005, 17'(write_page_select));
    m.issue(1'b0, MODE_IND_POST, 16'h8000, 17'h08002);
    m.issue(1'b1, MODE_IND_POST, 16'h8010, 17'h08012);
    chk_rsp(1'b0, 16'h8002, 10'h200, 1'b0);
    m.idle();
    chk_rsp(1'b1, 16'h8012, 10'h005, 1'b0);
    m.idle();
    chk_bit("valid idle", 1'b0, rsp.valid);
    // Reset in mid-run restores both pages
    reset_n = 1'b0;
    @(negedge clk);
    reset_n = 1'b1;
    chk_vec("rd page rst2", 17'h001, 17'(read_page_select));
    chk_vec("wr page rst2", 17'h001, 17'(write_page_select));
    chk_bit("trap rst2", 1'b0, addr_err_trap);
    final_report();
  end
endmodule
